// ### lss_consts.svh
`ifndef LSS_CONSTS_SVH
`define LSS_CONSTS_SVH

// Clock figures: 40 MHz system clock, fastest shift clock 125 ns
`define LSS_MCLK_NS 25
`define LSS_SCLK_MIN_NS 125
`define LSS_SCLK_MIN_CYC ((`LSS_SCLK_MIN_NS + `LSS_MCLK_NS - 1) / `LSS_MCLK_NS)

// Scan geometry
`define LSS_DUMMY_PIX 9'h064
`define LSS_ACT_400 9'h0E8
`define LSS_ACT_300 9'h0AE
`define LSS_ACT_200 9'h074
`define LSS_ACT_100 9'h03A
`define LSS_EOS_400 9'h0D0
`define LSS_EOS_300 9'h096
`define LSS_EOS_200 9'h05C
`define LSS_EOS_100 9'h022

// Shift clocks on which the resolution select level is sampled
`define LSS_RS_FIRST 9'h015
`define LSS_RS_SECOND 9'h02D

// Pixel buffer
`define LSS_FIFO_DEPTH 16
`define LSS_LEVEL_W 8

`endif

// ### lss_pkg.sv
package lss_pkg;
	typedef enum logic [2:0] {
		LSS_IDLE = 3'b001,
		LSS_INIT = 3'b010,
		LSS_XFER = 3'b100
	} lss_state_e;

	typedef enum logic [1:0] {
		LSS_DPI_400 = 2'b00,
		LSS_DPI_300 = 2'b01,
		LSS_DPI_200 = 2'b10,
		LSS_DPI_100 = 2'b11
	} lss_mode_e;

	typedef struct packed {
		logic [8:0] index;
		logic [7:0] level;
	} lss_pix_s;
endpackage

// ### lss_sequencer.sv
// Behaviour
// - Start inputs sampled and scan register advanced only on shift clock falling edges.
// - Global start re-arms start logic and begins scan when this chip is first.
// - Chain start input, once armed, begins a line scan of this sensor.
// - End-of-scan pulse drives the next chip's chain start input.
// - Exactly one pixel presented per shift clock cycle.
// - 100 inactive pixels, then 232, 174, 116 or 58 active pixels.
// - Start pulses spaced at least one full scan; a new start restarts the scan.
// - Three states: initialization, integration-and-transfer, idle integrating.
// - Resolution select chooses 400, 300, 200 or 100 dpi.
// - First active pixel on clock 100 after start; earlier outputs invalid.
// - End-of-scan on pixel 208, 150, 92 or 34 per mode.
// - Output amplifier enabled for readout, disabled once readout finishes.
`include "lss_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Pixel buffer, output read combinationally from storage, honest full and empty
module lss_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] fill, next_fill;
	logic push, pop;

	// Handshake terms
	always_comb begin
		in_ready = (fill != DEPTH[AW:0]);
		out_valid = (fill != '0);
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	assign out_data = mem[rd_ptr];

	// Storage has no reset; only pointers and fill count need one
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill <= next_fill;
		end
	end

	a_fifo_bound: assert property (@(posedge mclk) disable iff (rst)
		(fill == DEPTH[AW:0]) && !pop |=> fill == DEPTH[AW:0] && !in_ready)
		else $error("fifo full flag lost");
endmodule

////////////////////////////////////////////////////////////////////////////////
// Scan sequencer, all shift-clock activity seen as falling edges on mclk
module lss_sequencer (
	input wire logic mclk,
	input wire logic rst,
	input wire logic shift_clock,
	input wire logic global_scan_start,
	input wire logic chain_start,
	input wire logic resolution_select,
	input wire logic [7:0] pixel_level,
	output logic [7:0] video_output,
	output logic pixel_valid,
	output logic end_of_scan,
	output logic amp_enable,
	output lss_pkg::lss_mode_e dpi_mode,
	output lss_pkg::lss_state_e scan_state,
	output logic [8:0] pixel_count,
	output lss_pkg::lss_pix_s pix_out,
	output logic pix_out_valid,
	input wire logic pix_out_ready,
	output logic pix_overflow
);
	// Pin synchronisers: stage 1 read only by stage 2
	logic [11:0] sync1, sync2;
	logic sclk_d;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= '0;
			sync2 <= '0;
			sclk_d <= 1'b0;
		end else begin
			sync1 <= {pixel_level, resolution_select, chain_start, global_scan_start,
				shift_clock};
			sync2 <= sync1;
			sclk_d <= sync2[0];
		end
	end

	logic sclk_fall, global_scan_start_s, si_s, rs_s;
	logic [7:0] level_s;
	assign sclk_fall = sclk_d && !sync2[0];
	assign global_scan_start_s = sync2[1];
	assign si_s = sync2[2];
	assign rs_s = sync2[3];
	assign level_s = sync2[11:4];

	lss_pkg::lss_state_e state, next_state;
	lss_pkg::lss_mode_e mode, next_mode;
	logic [8:0] count, next_count, last_cnt, eos_cnt;
	logic armed, next_armed, rs_first, next_rs_first, start;
	logic [7:0] next_video;
	logic next_valid, next_eos, next_amp, next_ovf;
	logic fifo_in_ready, push_want;
	logic [8:0] act_pix, eos_pix;

	// Per-mode scan lengths from the held mode, which avoids a loop through next_mode
	always_comb begin
		case (mode)
			lss_pkg::LSS_DPI_300: begin
				act_pix = `LSS_ACT_300;
				eos_pix = `LSS_EOS_300;
			end
			lss_pkg::LSS_DPI_200: begin
				act_pix = `LSS_ACT_200;
				eos_pix = `LSS_EOS_200;
			end
			lss_pkg::LSS_DPI_100: begin
				act_pix = `LSS_ACT_100;
				eos_pix = `LSS_EOS_100;
			end
			default: begin
				act_pix = `LSS_ACT_400;
				eos_pix = `LSS_EOS_400;
			end
		endcase
		last_cnt = `LSS_DUMMY_PIX - 9'h001 + act_pix;
		eos_cnt = `LSS_DUMMY_PIX - 9'h001 + eos_pix;
	end

	// Global start arms the chain; first chip has its chain input held high
	assign start = sclk_fall && si_s && (global_scan_start_s || armed);

	// Scan state, counter and resolution decode
	always_comb begin
		next_state = state;
		next_count = count;
		next_armed = armed;
		next_mode = mode;
		next_rs_first = rs_first;
		if (sclk_fall) begin
			if (global_scan_start_s) begin
				next_armed = !si_s;
			end else if (start) begin
				next_armed = 1'b0;
			end
			if (start) begin
				// A start mid-scan restarts; the controller spaces starts apart
				next_state = lss_pkg::LSS_INIT;
				next_count = '0;
			end else begin
				case (state)
					lss_pkg::LSS_INIT: begin
						next_count = count + 9'h001;
						if (count == `LSS_RS_FIRST) begin
							next_rs_first = rs_s;
						end
						if (count == `LSS_RS_SECOND) begin
							// High-high 400, low-low 300, low-high 200, high-low 100
							next_mode = lss_pkg::lss_mode_e'({rs_first ^ rs_s, !rs_s});
						end
						if (count == `LSS_DUMMY_PIX - 9'h001) begin
							next_state = lss_pkg::LSS_XFER;
						end
					end
					lss_pkg::LSS_XFER: begin
						if (count == last_cnt) begin
							next_state = lss_pkg::LSS_IDLE;
						end else begin
							next_count = count + 9'h001;
						end
					end
					lss_pkg::LSS_IDLE: begin
						next_state = lss_pkg::LSS_IDLE;
					end
					default: begin
						next_state = lss_pkg::LSS_IDLE;
					end
				endcase
			end
		end
	end

	// Outputs follow the next scan position so they change only on falls
	always_comb begin
		next_valid = (next_state == lss_pkg::LSS_XFER);
		next_amp = next_valid;
		next_eos = next_valid && (next_count == eos_cnt);
		next_video = video_output;
		if (sclk_fall) begin
			next_video = next_valid ? level_s : 8'h00;
		end
		push_want = sclk_fall && next_valid;
		// Sensor cannot be stalled, so a full buffer drops and flags
		next_ovf = pix_overflow || (push_want && !fifo_in_ready);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= lss_pkg::LSS_IDLE;
			count <= '0;
			armed <= 1'b0;
			mode <= lss_pkg::LSS_DPI_400;
			rs_first <= 1'b1;
			video_output <= 8'h00;
			pixel_valid <= 1'b0;
			end_of_scan <= 1'b0;
			amp_enable <= 1'b0;
			pix_overflow <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			armed <= next_armed;
			mode <= next_mode;
			rs_first <= next_rs_first;
			video_output <= next_video;
			pixel_valid <= next_valid;
			end_of_scan <= next_eos;
			amp_enable <= next_amp;
			pix_overflow <= next_ovf;
		end
	end

	assign dpi_mode = mode;
	assign scan_state = state;
	assign pixel_count = count;

	// Active pixels queued for the downstream consumer
	lss_fifo #(.WIDTH(17), .DEPTH(`LSS_FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_data({next_count, level_s}),
		.in_valid(push_want),
		.in_ready(fifo_in_ready),
		.out_data(pix_out),
		.out_valid(pix_out_valid),
		.out_ready(pix_out_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_fall_only: assert property (@(posedge mclk) disable iff (rst)
		!sclk_fall |=> $stable(state) && $stable(count))
		else $error("scan moved without shift clock fall");
	a_global_scan_start_start: assert property (@(posedge mclk) disable iff (rst)
		sclk_fall && global_scan_start_s && si_s |=> state == lss_pkg::LSS_INIT && count == 9'h000)
		else $error("global start did not begin scan");
	a_chain_start: assert property (@(posedge mclk) disable iff (rst)
		sclk_fall && armed && si_s |=> state == lss_pkg::LSS_INIT && !armed)
		else $error("chain start did not begin scan");
	a_pixel_step: assert property (@(posedge mclk) disable iff (rst)
		sclk_fall && !start && state == lss_pkg::LSS_XFER && count != last_cnt
		|=> count == $past(count) + 9'h001)
		else $error("pixel counter did not step");
	a_init_len: assert property (@(posedge mclk) disable iff (rst)
		sclk_fall && !start && state == lss_pkg::LSS_INIT && count == 9'h063
		|=> state == lss_pkg::LSS_XFER && count == 9'h064)
		else $error("preamble length wrong");
	a_valid_range: assert property (@(posedge mclk) disable iff (rst)
		pixel_valid |-> count >= `LSS_DUMMY_PIX && video_output == $past(level_s, 1) || !$rose(pixel_valid))
		else $error("valid outside active pixels");
	a_eos_pixel: assert property (@(posedge mclk) disable iff (rst)
		end_of_scan |-> pixel_valid && count == eos_cnt)
		else $error("end of scan on wrong pixel");
	a_return_idle: assert property (@(posedge mclk) disable iff (rst)
		sclk_fall && !start && state == lss_pkg::LSS_XFER && count == last_cnt
		|=> state == lss_pkg::LSS_IDLE ##1 !amp_enable)
		else $error("scan did not end");
	a_amp_window: assert property (@(posedge mclk) disable iff (rst)
		$fell(amp_enable) |-> state == lss_pkg::LSS_IDLE || state == lss_pkg::LSS_INIT)
		else $error("amplifier off during readout");
endmodule

// ### lss_ctrl_model.sv
////////////////////////////////////////
// Scanner controller in front of the sensor pins
module lss_ctrl_model (
	input wire logic mclk,
	input wire logic go,
	input wire logic global_scan_start_en,
	input wire logic chain_en,
	input wire logic [1:0] mode,
	input wire logic [8:0] nfalls,
	output logic busy,
	output logic shift_clock,
	output logic global_scan_start,
	output logic chain_start,
	output logic resolution_select,
	output logic [7:0] pixel_level
);
	timeunit 1ns;
	timeprecision 1ps;
	int k;

	// Select level per mode; samples land on clocks 21 and 45
	function automatic logic rs_level(input logic [1:0] m, input int c);
		return m[1] ? (m[0] ^ (c > 32)) : !m[0];
	endfunction

	// Idle shift clock stands high; inputs move at rises, stable over falls
	initial begin
		busy = 1'b0;
		shift_clock = 1'b1;
		global_scan_start = 1'b0;
		chain_start = 1'b0;
		resolution_select = 1'b1;
		pixel_level = 8'h00;
	end

	// One frame of nfalls shift clocks, 250 ns period, 50 percent duty
	// Longest frame stays well inside the start-to-start bound
	always begin
		@(posedge mclk);
		if (go === 1'b1) begin
			busy <= 1'b1;
			for (k = 0; k < nfalls; k++) begin
				global_scan_start <= global_scan_start_en && k == 0;
				chain_start <= chain_en && k == 0;
				resolution_select <= rs_level(mode, k);
				pixel_level <= k[7:0] ^ 8'h5A;
				repeat (5) @(posedge mclk);
				shift_clock <= 1'b0;
				repeat (5) @(posedge mclk);
				shift_clock <= 1'b1;
			end
			// Released data line must not look like the last pixel
			pixel_level <= ~pixel_level;
			busy <= 1'b0;
		end
	end
endmodule

// ### linear_sensor_scan_sequencer_tb.sv
////////////////////////////////////////
module linear_sensor_scan_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, go = 1'b0, global_scan_start_en = 1'b0, chain_en = 1'b0, ready = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [8:0] nfalls = 9'h000;
	logic busy, shift_clock, global_scan_start, chain_start, resolution_select;
	logic [7:0] pixel_level, video_output, first_lvl;
	logic pixel_valid, end_of_scan, amp_enable, pix_out_valid, pix_overflow, pv_d, eos_d;
	lss_pkg::lss_mode_e dpi_mode;
	lss_pkg::lss_state_e scan_state;
	logic [8:0] pixel_count, first_cnt, eos_cnt;
	lss_pkg::lss_pix_s pix_out, first_pop;
	int err_count = 0, checks_done = 0, pv_cyc, eos_cyc, pops, amp_bad = 0, init_seen;
	logic [8:0] act [4] = '{9'h0E8, 9'h0AE, 9'h074, 9'h03A};
	logic [8:0] eos [4] = '{9'h0D0, 9'h096, 9'h05C, 9'h022};

	// 40 MHz system clock
	always #12.5 mclk = ~mclk;

	lss_ctrl_model ctrl (.mclk, .go, .global_scan_start_en, .chain_en, .mode, .nfalls, .busy, .shift_clock,
		.global_scan_start, .chain_start, .resolution_select, .pixel_level);

	lss_sequencer dut (.mclk, .rst, .shift_clock, .global_scan_start, .chain_start,
		.resolution_select, .pixel_level, .video_output, .pixel_valid, .end_of_scan,
		.amp_enable, .dpi_mode, .scan_state, .pixel_count, .pix_out, .pix_out_valid,
		.pix_out_ready(ready), .pix_overflow);

	// Monitor: cycle counts and first values of each frame
	always @(posedge mclk) begin
		pv_cyc += pixel_valid;
		eos_cyc += end_of_scan;
		if (pixel_valid && !pv_d) begin
			first_cnt = pixel_count;
			first_lvl = video_output;
		end
		if (end_of_scan && !eos_d) eos_cnt = pixel_count;
		if (pix_out_valid && ready) begin
			if (pops == 0) first_pop = pix_out;
			pops++;
		end
		if (amp_enable !== pixel_valid) amp_bad++;
		if (scan_state === lss_pkg::LSS_INIT) init_seen = 1;
		pv_d = pixel_valid;
		eos_d = end_of_scan;
	end

	////////////////////////////////////////
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// One controller frame; counters cleared off the sampling edge
	task automatic run(input logic g, input logic c, input logic [1:0] m, input logic [8:0] n);
		int i;
		@(negedge mclk);
		pv_cyc = 0;
		eos_cyc = 0;
		pops = 0;
		init_seen = 0;
		@(posedge mclk);
		global_scan_start_en <= g;
		chain_en <= c;
		mode <= m;
		nfalls <= n;
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 4000 && busy !== 1'b0; i++)
			@(posedge mclk);
		if (i == 4000) begin
			chk("frame end", 0, 1);
			report_and_stop();
		end else begin
			repeat (8) @(posedge mclk);
		end
	endtask

	////////////////////////////////////////
	// Unarmed chain start ignored; global start without chain only arms
	task automatic t_chain();
		run(1'b0, 1'b1, 2'h0, 9'h014);
		chk("unarmed count", 0, pixel_count);
		run(1'b1, 1'b0, 2'h0, 9'h014);
		chk("armed state", lss_pkg::LSS_IDLE, scan_state);
		chk("armed valid", 0, pv_cyc);
		run(1'b0, 1'b1, 2'h0, 9'h14F);
		chk("chain pixels", 2320, pv_cyc);
		chk("chain first", 9'h064, first_cnt);
	endtask

	// Every mode, full frame, consumer always ready
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			run(1'b1, 1'b1, m[1:0], act[m] + 9'h067);
			chk("valid cycles", act[m] * 10, pv_cyc);
			chk("eos cycles", 10, eos_cyc);
			chk("first count", 9'h064, first_cnt);
			chk("first level", 8'h3E, first_lvl);
			chk("eos count", eos[m] + 9'h063, eos_cnt);
			chk("mode", m, dpi_mode);
			chk("init seen", 1, init_seen);
			chk("end state", lss_pkg::LSS_IDLE, scan_state);
			chk("idle video", 0, video_output);
			chk("amp mismatch", 0, amp_bad);
			chk("pops", act[m], pops);
			chk("head", {9'h064, 8'h3E}, first_pop);
		end
	endtask

	// Start in mid-frame restarts the count; pushes counted, as a cut scan leaves valid standing
	task automatic t_restart();
		run(1'b1, 1'b1, 2'h1, 9'h096);
		chk("cut state", lss_pkg::LSS_XFER, scan_state);
		run(1'b1, 1'b1, 2'h1, 9'h113);
		chk("restart pixels", 9'h0AE, pops);
		chk("restart first", 9'h064, first_cnt);
		chk("restart eos", 10, eos_cyc);
		chk("restart end", lss_pkg::LSS_IDLE, scan_state);
	endtask

	// Consumer stalls: buffer fills to 16, drops set sticky flag
	task automatic t_fifo();
		ready <= 1'b0;
		run(1'b1, 1'b1, 2'h0, 9'h14F);
		chk("overflow", 1, pix_overflow);
		chk("held", 1, pix_out_valid);
		ready <= 1'b1;
		repeat (24) @(posedge mclk);
		chk("drained", 16, pops);
		chk("empty", 0, pix_out_valid);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		chk("overflow cleared", 0, pix_overflow);
		chk("reset mode", lss_pkg::LSS_DPI_400, dpi_mode);
	endtask

	// Reset six cycles, then the scenarios
	initial begin
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		t_chain();
		t_modes();
		t_restart();
		t_fifo();
		report_and_stop();
	end
endmodule
